// File: pkg/cbf_pkg.sv
// constants for the breaker-failure supervision block
package cbf_pkg;
	// ==========================================
	// timing
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned CYCLE_MS      = 5;
	localparam int unsigned CYCLE_CLKS    = CLK_HZ / 1000 * CYCLE_MS;
	localparam int unsigned RETRIP_DEF_MS = 100;
	localparam int unsigned FAIL_DEF_MS   = 200;
	localparam int unsigned TW            = 20;
	localparam logic [19:0] RETRIP_RST    = 20'(RETRIP_DEF_MS / CYCLE_MS);
	localparam logic [19:0] FAIL_RST      = 20'(FAIL_DEF_MS / CYCLE_MS);
	// ==========================================
	// register offsets
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_RT_DLY  = 8'h04;
	localparam logic [7:0] A_FL_DLY  = 8'h08;
	localparam logic [7:0] A_PH_THR  = 8'h0C;
	localparam logic [7:0] A_RES_THR = 8'h10;
	localparam logic [7:0] A_EVT_EN  = 8'h14;
	localparam logic [7:0] A_STATUS  = 8'h18;
	localparam logic [7:0] A_LOG_SEL = 8'h1C;
	localparam logic [7:0] A_LOG_TS  = 8'h20;
	localparam logic [7:0] A_LOG_INF = 8'h24;
	localparam logic [7:0] A_LOG_CUR = 8'h28;
	localparam logic [7:0] A_LOG_TIM = 8'h2C;
	// ==========================================
	// fields and reset values
	localparam int unsigned  F_MODE   = 0;
	localparam int unsigned  F_RT_EN  = 4;
	localparam int unsigned  F_RES    = 5;
	localparam logic [31:0]  CTRL_RST = 32'h0000_0010;
	localparam logic [15:0]  PH_RST   = 16'h00C8;
	localparam logic [15:0]  RES_RST  = 16'h04B0;
	localparam logic [15:0]  EVT_RST  = 16'hFFFF;
	// ==========================================
	// operating modes
	localparam logic [3:0] M_CUR        = 4'h0;
	localparam logic [3:0] M_DO         = 4'h1;
	localparam logic [3:0] M_SIG        = 4'h2;
	localparam logic [3:0] M_CUR_AND_DO = 4'h3;
	localparam logic [3:0] M_CUR_OR_DO  = 4'h4;
	localparam logic [3:0] M_CUR_AND_SG = 4'h5;
	localparam logic [3:0] M_CUR_OR_SG  = 4'h6;
	localparam logic [3:0] M_SG_AND_DO  = 4'h7;
	localparam logic [3:0] M_SG_OR_DO   = 4'h8;
	localparam logic [3:0] M_CUR_OR_SG2 = 4'h9;
	localparam logic [3:0] M_ALL_AND    = 4'hA;
	// ==========================================
	// events and log
	localparam int unsigned EV_N      = 8;
	localparam int unsigned LOG_DEPTH = 12;
	localparam int unsigned LOG_W     = 111;
endpackage

// File: src/cbf_timer.sv
// breaker-failure pick-up, timers, events and operation log
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
module cbf_timer
	import cbf_pkg::*;
#(
	parameter int unsigned TICK_CLKS = CYCLE_CLKS
) (
	input  wire logic        ref_clk,             // 100 MHz clock
	input  wire logic        srst,                // sync reset
	input  wire logic        ce,                  // clock enable
	input  wire logic [7:0]  addr,                // register address
	input  wire logic [31:0] wdata,               // write data
	input  wire logic        wr,                  // write strobe
	input  wire logic        rd,                  // read strobe
	output logic      [31:0] rdata,               // read data
	input  wire logic [15:0] phase_current,       // highest phase current
	input  wire logic [15:0] residual_input_one,  // residual channel one
	input  wire logic [15:0] residual_input_two,  // residual channel two
	input  wire logic [15:0] residual_calc,       // calculated residual
	input  wire logic        trip_mon,            // primary trip output state
	input  wire logic        signal_in,           // digital start input
	input  wire logic        block_in,            // block input
	input  wire logic [31:0] timestamp,           // time stamp
	input  wire logic [2:0]  setting_group,       // active setting group
	output logic             start_out,           // start
	output logic             retrip_out,          // retrip coil
	output logic             breaker_failure_out, // incomer trip
	output logic             blocked_out,         // blocked
	output logic             event_valid,         // event pulse
	output logic      [3:0]  event_code,          // {condition, on}
	output logic      [31:0] event_stamp,         // event time
	output logic      [15:0] event_phase,         // phase current
	output logic      [15:0] event_res            // residual current
);
	// ==========================================
	// settings
	logic [31:0]   ctrl;
	logic [TW-1:0] rt_dly;
	logic [TW-1:0] fl_dly;
	logic [15:0]   ph_thr;
	logic [15:0]   res_thr;
	logic [15:0]   evt_en;
	logic [3:0]    log_sel;
	logic [3:0]    mode;
	logic          rt_en;
	logic [1:0]    res_src;
	assign mode    = ctrl[F_MODE +: 4];
	assign rt_en   = ctrl[F_RT_EN];
	assign res_src = ctrl[F_RES +: 2];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl    <= CTRL_RST;
			rt_dly  <= RETRIP_RST;
			fl_dly  <= FAIL_RST;
			ph_thr  <= PH_RST;
			res_thr <= RES_RST;
			evt_en  <= EVT_RST;
			log_sel <= '0;
		end else if (ce && wr) begin
			case (addr)
				A_CTRL:    ctrl    <= wdata & 32'h0000_007F;
				A_RT_DLY:  rt_dly  <= wdata[TW-1:0];
				A_FL_DLY:  fl_dly  <= wdata[TW-1:0];
				A_PH_THR:  ph_thr  <= wdata[15:0];
				A_RES_THR: res_thr <= wdata[15:0];
				A_EVT_EN:  evt_en  <= wdata[15:0];
				A_LOG_SEL: log_sel <= wdata[3:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// program-cycle tick, one delay step each
	logic [19:0] tick_cnt;
	logic        tick;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (ce) begin
			tick     <= (tick_cnt == 20'(TICK_CLKS - 1));
			tick_cnt <= (tick_cnt == 20'(TICK_CLKS - 1)) ? '0 : tick_cnt + 20'd1;
		end
	end

	// ==========================================
	// pick-up comparators and criterion
	logic [15:0] res_val;
	logic        cur_ph;
	logic        cur_res;
	logic        cur;
	logic        pick;
	logic        run;
	always_comb begin
		case (res_src)
			2'd1:    res_val = residual_input_one;
			2'd2:    res_val = residual_input_two;
			2'd3:    res_val = residual_calc;
			default: res_val = '0;
		endcase
	end
	assign cur_ph  = phase_current > ph_thr;
	assign cur_res = (res_src != 2'd0) && (res_val > res_thr);
	assign cur     = cur_ph | cur_res;

	always_comb begin
		case (mode)
			M_CUR:        {pick, run} = {2{cur}};
			M_DO:         {pick, run} = {2{trip_mon}};
			M_SIG:        {pick, run} = {2{signal_in}};
			M_CUR_AND_DO: {pick, run} = {cur, cur & trip_mon};
			M_CUR_OR_DO:  {pick, run} = {2{cur | trip_mon}};
			M_CUR_AND_SG: {pick, run} = {cur, cur & signal_in};
			M_CUR_OR_SG, M_CUR_OR_SG2: {pick, run} = {2{cur | signal_in}};
			M_SG_AND_DO:  {pick, run} = {signal_in, signal_in & trip_mon};
			M_SG_OR_DO:   {pick, run} = {2{signal_in | trip_mon}};
			M_ALL_AND:    {pick, run} = {cur, cur & trip_mon & signal_in};
			default:      {pick, run} = 2'b00;
		endcase
	end

	// ==========================================
	// start, block and timers
	logic          next_start;
	logic          next_blocked;
	logic          act;
	logic [TW-1:0] rt_cnt;
	logic [TW-1:0] fl_cnt;
	logic          next_retrip;
	logic          next_fail;
	assign next_start   = pick & ~block_in;
	assign next_blocked = pick & block_in;
	assign act          = next_start & run;
	assign next_retrip  = act & rt_en & (rt_cnt >= rt_dly);
	assign next_fail    = act & (fl_cnt >= fl_dly);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rt_cnt <= '0;
			fl_cnt <= '0;
		end else if (ce) begin
			if (!act) begin
				rt_cnt <= '0;
				fl_cnt <= '0;
			end else if (tick) begin
				if (rt_en && rt_cnt != '1)
					rt_cnt <= rt_cnt + 1'b1;
				if (fl_cnt != '1)
					fl_cnt <= fl_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			start_out           <= 1'b0;
			blocked_out         <= 1'b0;
			retrip_out          <= 1'b0;
			breaker_failure_out <= 1'b0;
		end else if (ce) begin
			start_out           <= next_start;
			blocked_out         <= next_blocked;
			retrip_out          <= next_retrip;
			breaker_failure_out <= next_fail;
		end
	end

	// ==========================================
	// events: pending on/off flags per condition
	logic [EV_N-1:0] cond_q;
	logic [EV_N-1:0] cond_prev;
	logic [EV_N-1:0] rise;
	logic [EV_N-1:0] fall;
	logic [15:0]     pend;
	logic [15:0]     grant;
	logic [3:0]      sel;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cond_q    <= '0;
			cond_prev <= '0;
		end else if (ce) begin
			cond_q    <= {cur_res, cur_ph, signal_in, trip_mon,
				next_blocked, next_fail, next_retrip, next_start};
			cond_prev <= cond_q;
		end
	end
	assign rise = cond_q & ~cond_prev;
	assign fall = ~cond_q & cond_prev;
	// pend[2i+1] is the on event of condition i, pend[2i] the off event
	for (genvar i = 0; i < EV_N; i++) begin : g_ev
		always_ff @(posedge ref_clk) begin
			if (srst) begin
				pend[2*i+1] <= 1'b0;
				pend[2*i]   <= 1'b0;
			end else if (ce) begin
				pend[2*i+1] <= (pend[2*i+1] & ~grant[2*i+1]) | (rise[i] & evt_en[2*i+1]);
				pend[2*i]   <= (pend[2*i] & ~grant[2*i]) | (fall[i] & evt_en[2*i]);
			end
		end
	end

	always_comb begin
		sel   = '0;
		grant = '0;
		for (int k = 15; k >= 0; k--) begin
			if (pend[k]) begin
				sel   = 4'(k);
				grant = 16'h0000;
				grant[k] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			event_valid <= 1'b0;
			event_code  <= '0;
			event_stamp <= '0;
			event_phase <= '0;
			event_res   <= '0;
		end else if (ce) begin
			event_valid <= |pend;
			event_code  <= sel;
			event_stamp <= timestamp;
			event_phase <= phase_current;
			event_res   <= res_val;
		end
	end

	// ==========================================
	// operation log, written on output on-events
	logic [LOG_W-1:0] log_mem [LOG_DEPTH];
	logic [3:0]       wptr;
	logic [3:0]       log_cnt;
	logic [2:0]       lidx;
	logic [TW-1:0]    rt_rem;
	logic [TW-1:0]    fl_rem;
	assign rt_rem = (rt_en && rt_dly > rt_cnt) ? rt_dly - rt_cnt : '0;
	assign fl_rem = (fl_dly > fl_cnt) ? fl_dly - fl_cnt : '0;
	always_comb begin
		lidx = '0;
		for (int k = 3; k >= 0; k--)
			if (rise[k])
				lidx = 3'(k);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wptr    <= '0;
			log_cnt <= '0;
		end else if (ce && |rise[3:0]) begin
			log_mem[wptr] <= {setting_group, fl_rem, rt_rem, res_val,
				phase_current, lidx, 1'b1, timestamp};
			wptr <= (wptr == 4'(LOG_DEPTH - 1)) ? '0 : wptr + 4'd1;
			if (log_cnt != 4'(LOG_DEPTH))
				log_cnt <= log_cnt + 4'd1;
		end
	end

	// ==========================================
	// register read
	logic [LOG_W-1:0] ent;
	logic [31:0]      next_rdata;
	assign ent = (log_sel < 4'(LOG_DEPTH)) ? log_mem[log_sel] : '0;
	always_comb begin
		case (addr)
			A_CTRL:    next_rdata = ctrl;
			A_RT_DLY:  next_rdata = 32'(rt_dly);
			A_FL_DLY:  next_rdata = 32'(fl_dly);
			A_PH_THR:  next_rdata = {16'h0000, ph_thr};
			A_RES_THR: next_rdata = {16'h0000, res_thr};
			A_EVT_EN:  next_rdata = {16'h0000, evt_en};
			A_STATUS:  next_rdata = {16'h0000, wptr, log_cnt, cond_q};
			A_LOG_SEL: next_rdata = {28'h000_0000, log_sel};
			A_LOG_TS:  next_rdata = ent[31:0];
			A_LOG_INF: next_rdata = {25'h000_0000, ent[110:108], ent[35:32]};
			A_LOG_CUR: next_rdata = ent[67:36];
			A_LOG_TIM: next_rdata = {ent[107:98], 2'b00, ent[87:68]};
			default:   next_rdata = '0;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (srst)
			rdata <= '0;
		else if (ce)
			rdata <= rd ? next_rdata : '0;
	end

	// ==========================================
	// checks
	property p_cur_start;
		@(posedge ref_clk) disable iff (srst)
		ce && mode == M_CUR && cur && !block_in |=> start_out;
	endproperty
	a_cur_start: assert property (p_cur_start) else $error("no start on overcurrent");
	property p_cur_clear;
		@(posedge ref_clk) disable iff (srst)
		ce && mode == M_CUR && !cur |=> rt_cnt == '0 && !breaker_failure_out;
	endproperty
	a_cur_clear: assert property (p_cur_clear) else $error("timer kept on low current");
	property p_and_hold;
		@(posedge ref_clk) disable iff (srst)
		ce && mode == M_CUR_AND_DO && !trip_mon |=> fl_cnt == '0;
	endproperty
	a_and_hold: assert property (p_and_hold) else $error("timer ran without trip");
	property p_or_pick;
		@(posedge ref_clk) disable iff (srst)
		ce && mode == M_CUR_OR_DO && trip_mon && !block_in |=> start_out;
	endproperty
	a_or_pick: assert property (p_or_pick) else $error("trip alone did not start");
	property p_fail_exp;
		@(posedge ref_clk) disable iff (srst)
		ce && act && fl_cnt >= fl_dly |=> breaker_failure_out;
	endproperty
	a_fail_exp: assert property (p_fail_exp) else $error("failure not on expiry");
	property p_no_retrip;
		@(posedge ref_clk) disable iff (srst)
		ce && !rt_en |=> !retrip_out;
	endproperty
	a_no_retrip: assert property (p_no_retrip) else $error("retrip while disabled");
	property p_block;
		@(posedge ref_clk) disable iff (srst)
		ce && pick && block_in |=> blocked_out && !start_out;
	endproperty
	a_block: assert property (p_block) else $error("block not honoured");
	sequence s_drop;
		ce && !act;
	endsequence
	property p_drop;
		@(posedge ref_clk) disable iff (srst)
		s_drop |=> rt_cnt == '0 && fl_cnt == '0 && !retrip_out && !breaker_failure_out;
	endproperty
	a_drop: assert property (p_drop) else $error("outputs held after drop");
	property p_log_wrap;
		@(posedge ref_clk) disable iff (srst)
		wptr < 4'(LOG_DEPTH);
	endproperty
	a_log_wrap: assert property (p_log_wrap) else $error("log pointer out of range");
endmodule // cbf_timer

// File: dv/cbf_breaker_model.sv
// contact model of the primary breaker trip output
`timescale 1ns/10ps
module cbf_breaker_model (
	input  wire logic ref_clk,  // clock
	input  wire logic trip_cmd, // primary trip command
	output logic      trip_mon  // contact state seen by the block
);
	// contact follows its coil command one cycle late, like a relay
	always_ff @(posedge ref_clk) begin
		trip_mon <= trip_cmd;
	end
endmodule // cbf_breaker_model

// File: dv/breaker_failure_timer_logic_bench.sv
// self-checking bench for the breaker-failure block
`timescale 1ns/10ps
module breaker_failure_timer_logic_bench;
	import cbf_pkg::*;
	// ==========================================
	// stimulus and observation
	logic        ref_clk = 1'b0;
	logic        srst    = 1'b1;
	logic [7:0]  addr    = 8'h00;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic [15:0] ph      = 16'h0000;
	logic [15:0] r1      = 16'h0000;
	logic [15:0] r2      = 16'h0000;
	logic        cmd     = 1'b0;
	logic        sig     = 1'b0;
	logic        blk     = 1'b0;
	logic        ce      = 1'b1;
	logic [31:0] ts      = 32'h0000_0000;
	logic [2:0]  grp     = 3'h3;
	logic [31:0] rdata;
	logic        trip_mon;
	logic        start_out;
	logic        retrip_out;
	logic        breaker_failure_out;
	logic        blocked_out;
	logic        event_valid;
	logic [3:0]  event_code;
	logic [31:0] event_stamp;
	logic [15:0] event_phase;
	logic [15:0] event_res;
	logic [15:0] seen    = 16'h0000;
	logic [31:0] ev_ts;
	logic [31:0] ev_pv;
	logic [31:0] d;
	int          n_fail  = 0;
	int          samples_checked = 0;
	wire  [3:0]  o = {blocked_out, breaker_failure_out, retrip_out, start_out};
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	cbf_timer #(.TICK_CLKS(10)) cbf_timer_i (
		.ref_clk(ref_clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .phase_current(ph),
		.residual_input_one(r1), .residual_input_two(r2), .residual_calc(r2),
		.trip_mon(trip_mon), .signal_in(sig), .block_in(blk), .timestamp(ts),
		.setting_group(grp), .start_out(start_out), .retrip_out(retrip_out),
		.breaker_failure_out(breaker_failure_out), .blocked_out(blocked_out),
		.event_valid(event_valid), .event_code(event_code),
		.event_stamp(event_stamp), .event_phase(event_phase), .event_res(event_res));
	cbf_breaker_model cbf_breaker_model_i (
		.ref_clk(ref_clk), .trip_cmd(cmd), .trip_mon(trip_mon));
	always @(posedge ref_clk) begin
		if (event_valid === 1'b1) begin
			seen[event_code] <= 1'b1;
			ev_ts <= event_stamp;
			ev_pv <= {event_res, event_phase};
		end
	end
	// ==========================================
	// helpers
	task automatic test_done;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
		chk(nm, e, d);
	endtask
	task automatic set_in(input logic [15:0] p, r, input logic c, s, b);
		@(posedge ref_clk);
		ph <= p;
		r1 <= r;
		cmd <= c;
		sig <= s;
		blk <= b;
	endtask
	task automatic cfg(input logic [3:0] m, input logic rt);
		wreg(A_CTRL, 32'(m) | (32'(rt) << F_RT_EN) | (32'h1 << F_RES));
	endtask
	// waits up to n cycles for output b to reach v
	task automatic wait_o(input int b, input logic v, input int n, input string nm);
		for (int i = 0; i < n && o[b] !== v; i++)
			@(negedge ref_clk);
		chk(nm, 32'(v), 32'(o[b]));
		if (o[b] !== v)
			test_done;
	endtask
	// output b must stay at v for n cycles
	task automatic hold_o(input int b, input logic v, input int n, input string nm);
		for (int i = 0; i < n && o[b] === v; i++)
			@(negedge ref_clk);
		chk(nm, 32'(v), 32'(o[b]));
	endtask
	// ==========================================
	// scenarios
	task automatic t_defaults;
		rchk("ctrl", A_CTRL, CTRL_RST);
		rchk("retrip delay", A_RT_DLY, 32'(RETRIP_RST));
		rchk("fail delay", A_FL_DLY, 32'(FAIL_RST));
		rchk("phase thr", A_PH_THR, 32'(PH_RST));
		rchk("res thr", A_RES_THR, 32'(RES_RST));
		rchk("evt en", A_EVT_EN, 32'(EVT_RST));
		rchk("unmapped", 8'h40, 32'h0000_0000);
	endtask
	task automatic t_log;
		for (int k = 1; k <= 13; k++) begin
			@(posedge ref_clk);
			ts <= 32'(k);
			set_in(16'h0100 + 16'(k), 16'h0000, 1'b0, 1'b0, 1'b0);
			repeat (3) @(posedge ref_clk);
			set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
			repeat (8) @(posedge ref_clk);
		end
		wreg(A_LOG_SEL, 32'h0000_0000);
		rchk("log0 stamp", A_LOG_TS, 32'h0000_000D);
		rchk("log0 info", A_LOG_INF, 32'h0000_0031);
		rchk("log0 cur", A_LOG_CUR, 32'h0000_010D);
		wreg(A_LOG_SEL, 32'h0000_0001);
		rchk("log1 stamp", A_LOG_TS, 32'h0000_0002);
		wreg(A_LOG_SEL, 32'h0000_000B);
		rchk("log11 stamp", A_LOG_TS, 32'h0000_000C);
		rchk("log status", A_STATUS, 32'h0000_1C00);
	endtask
	task automatic t_cur;
		cfg(M_CUR, 1'b1);
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
		repeat (6) @(posedge ref_clk);
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge ref_clk);
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
		wait_o(0, 1'b1, 4, "start");
		hold_o(1, 1'b0, 8, "retrip early");
		wait_o(1, 1'b1, 30, "retrip");
		chk("fail early", 32'h0, 32'(breaker_failure_out));
		wait_o(2, 1'b1, 90, "failure");
		hold_o(1, 1'b1, 5, "retrip hold");
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
		wait_o(2, 1'b0, 3, "fail drop");
		chk("retrip drop", 32'h0, 32'(retrip_out));
		set_in(16'h0000, 16'h0500, 1'b0, 1'b0, 1'b0);
		wait_o(0, 1'b1, 4, "residual start");
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_and;
		cfg(M_CUR_AND_DO, 1'b1);
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
		hold_o(1, 1'b0, 40, "retrip halted");
		set_in(16'h0100, 16'h0000, 1'b1, 1'b0, 1'b0);
		wait_o(1, 1'b1, 35, "retrip and");
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
		wait_o(1, 1'b0, 4, "trip drop");
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_or;
		cfg(M_CUR_OR_DO, 1'b1);
		set_in(16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0);
		wait_o(0, 1'b1, 4, "start or");
		wait_o(1, 1'b1, 35, "retrip or");
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
		hold_o(1, 1'b1, 6, "or hold");
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
		wait_o(1, 1'b0, 3, "or drop");
	endtask
	task automatic t_nort;
		cfg(M_CUR, 1'b0);
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
		hold_o(1, 1'b0, 60, "no retrip");
		wait_o(2, 1'b1, 50, "fail only");
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
		wait_o(2, 1'b0, 3, "fail drop");
	endtask
	task automatic t_sig;
		logic [3:0] m [8] = '{M_SIG, M_CUR_OR_SG, M_SG_OR_DO, M_CUR_OR_SG2,
			M_DO, M_SG_AND_DO, M_CUR_AND_SG, M_ALL_AND};
		logic [2:0] v [8] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
		// v holds {overcurrent, trip command, signal} for each mode
		for (int k = 0; k < 8; k++) begin
			cfg(m[k], 1'b1);
			set_in(v[k][2] ? 16'h0100 : 16'h0000, 16'h0000, v[k][1], v[k][0], 1'b0);
			wait_o(2, 1'b1, 100, "signal fail");
			set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
			wait_o(2, 1'b0, 3, "signal drop");
		end
		cfg(M_CUR_AND_SG, 1'b1);
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
		hold_o(2, 1'b0, 100, "and signal");
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_blk;
		cfg(M_CUR, 1'b1);
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b1);
		wait_o(3, 1'b1, 4, "blocked");
		chk("start blocked", 32'h0, 32'(start_out));
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge ref_clk);
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
		wait_o(0, 1'b1, 4, "start again");
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b1);
		wait_o(0, 1'b0, 4, "start reset");
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_evt(input logic [15:0] en, input logic e_on);
		wreg(A_EVT_EN, 32'(en));
		repeat (10) @(posedge ref_clk);
		seen <= 16'h0000;
		ts <= 32'(en);
		set_in(16'h0100, 16'h0123, 1'b0, 1'b0, 1'b0);
		repeat (12) @(posedge ref_clk);
		chk("start on", 32'(e_on), 32'(seen[1]));
		chk("phase on", 32'h1, 32'(seen[13]));
		chk("stamp", 32'(en), ev_ts);
		chk("values", 32'h0123_0100, ev_pv);
		set_in(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
		repeat (12) @(posedge ref_clk);
		chk("start off", 32'h1, 32'(seen[0]));
	endtask
	// clock enable low must freeze the outputs
	task automatic t_ce;
		set_in(16'h0100, 16'h0000, 1'b0, 1'b0, 1'b0);
		wait_o(0, 1'b1, 4, "ce start");
		@(posedge ref_clk);
		ce <= 1'b0;
		ph <= 16'h0000;
		repeat (5) @(negedge ref_clk);
		chk("ce freeze", 32'h1, 32'(start_out));
		@(posedge ref_clk);
		ce <= 1'b1;
		wait_o(0, 1'b0, 4, "ce release");
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		t_defaults;
		t_log;
		wreg(A_RT_DLY, 32'h0000_0002);
		wreg(A_FL_DLY, 32'h0000_0008);
		t_cur;
		t_and;
		t_or;
		t_nort;
		t_sig;
		t_blk;
		cfg(M_CUR, 1'b1);
		t_ce;
		t_evt(16'hFFFF, 1'b1);
		t_evt(16'hFFFD, 1'b0);
		test_done;
	end
endmodule // breaker_failure_timer_logic_bench
